// ### design/uisfc_pkg.sv
// Purpose: Shared constants and types for the interrupt status and FIFO control block
// Assumes: Three-bit register address and eight-bit data on the host bus
// Notes: Trigger tables are indexed by the two select bits
package uisfc_pkg;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;

	localparam int LEVEL_W = 6;
	localparam int CNT_W = 7;
	localparam int NF = 7;
	localparam int NE = 6;

	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_DMA = 3;
	localparam int FCR_TXT_LO = 4;
	localparam int FCR_RXT_LO = 6;

	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;

	localparam int LSR_ERR_LO = 1;
	localparam int LSR_ERR_HI = 4;
	localparam int MSR_DLT_LO = 0;
	localparam int MSR_DLT_HI = 3;

	localparam int EV_EMPTY = 0;
	localparam int EV_BELOW = 1;
	localparam int EV_MODEM = 2;
	localparam int EV_LINE = 3;
	localparam int EV_RTS = 4;
	localparam int EV_CTS = 5;

	localparam int F_LINE = 0;
	localparam int F_TO = 1;
	localparam int F_TX = 2;
	localparam int F_MODEM = 3;
	localparam int F_XOFF = 4;
	localparam int F_SPEC = 5;
	localparam int F_FLOW = 6;

	localparam logic [5:0] CODE_LINE = 6'h06;
	localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
	localparam logic [5:0] CODE_RECEIVE_READY = 6'h04;
	localparam logic [5:0] CODE_TRANSMIT_READY = 6'h02;
	localparam logic [5:0] CODE_MODEM = 6'h00;
	localparam logic [5:0] CODE_XOFF = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [5:0] CODE_EFR_MASK = 6'h30;
	localparam logic [7:0] ISR_RESET = 8'h01;

	localparam logic [LEVEL_W-1:0] TX_TRIG [4] = '{6'h10, 6'h08, 6'h18, 6'h1E};
	localparam logic [LEVEL_W-1:0] RX_TRIG [4] = '{6'h08, 6'h10, 6'h18, 6'h1E};

	localparam logic [CNT_W-1:0] TO_CHARS = 7'h04;
	localparam logic [CNT_W-1:0] TO_EXTRA_BITS = 7'h0C;

	typedef struct packed {
		logic [2:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} uisfc_bus_t;

	typedef struct packed {
		logic fifo_en;
		logic dma_mode;
		logic [1:0] tx_sel;
		logic [1:0] rx_sel;
	} uisfc_fcr_t;

	localparam uisfc_fcr_t FCR_RESET = '{default: '0};

	typedef enum logic [7:0] {
		SRC_NONE = 8'h01,
		SRC_LINE = 8'h02,
		SRC_TIMEOUT = 8'h04,
		SRC_RECEIVE_READY = 8'h08,
		SRC_TRANSMIT_READY = 8'h10,
		SRC_MODEM = 8'h20,
		SRC_XOFF = 8'h40,
		SRC_FLOW = 8'h80
	} uisfc_src_t;
endpackage

// ### design/uisfc_edge.sv
// Purpose: Rising edge detect on a vector of synchronous levels
// Assumes: Inputs already synchronous to clk
// Notes: Levels load during reset so a pin idling high gives no false rise
`timescale 1ns/1ps
module uisfc_edge #(
	parameter int W = 6
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev;

	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset) begin
					prev[i] <= level[i];
				end else begin
					prev[i] <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev[i];
		end
	endgenerate
endmodule

// ### design/uisfc_timeout.sv
// Purpose: Receive idle timer counted in bit-time enable pulses
// Assumes: bit_tick is a one-cycle pulse per bit time
// Notes: Fires once, then waits for a restart so a stale FIFO gives one event
`timescale 1ns/1ps
module uisfc_timeout #(
	parameter int CNT_W = 7
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic bit_tick,
	input wire logic restart,
	input wire logic run,
	input wire logic [CNT_W-1:0] limit,
	output logic expire
);
	logic [CNT_W-1:0] count;
	logic fired;

	always_ff @(posedge clk) begin
		if (reset || restart || !run) begin
			count <= '0;
			fired <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (bit_tick && !fired) begin
				if (count == limit - 1'b1) begin
					fired <= 1'b1;
					expire <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule

// ### design/uisfc_core.sv
// Purpose: Interrupt prioritiser and FIFO control register of one serial channel
// Assumes: Host strobes are one-cycle pulses synchronous to clk
// Notes: Shifters, FIFO storage and line/modem registers live outside
`timescale 1ns/1ps
module uisfc_core #(
	parameter int LEVEL_W = uisfc_pkg::LEVEL_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire uisfc_pkg::uisfc_bus_t bus,
	input wire logic divisor_sel,
	input wire logic enhanced_en,
	input wire logic auto_cts_en,
	input wire logic auto_rts_en,
	input wire logic [7:0] int_enable,
	input wire logic [7:0] line_status,
	input wire logic [7:0] modem_status,
	input wire logic cts_n,
	input wire logic rts_n,
	input wire logic xoff_match,
	input wire logic xon_match,
	input wire logic special_match,
	input wire logic rx_push,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	input wire logic [LEVEL_W-1:0] rx_level,
	input wire logic [LEVEL_W-1:0] tx_level,
	output logic [7:0] rd_data,
	output uisfc_pkg::uisfc_fcr_t fifo_control_reg,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic irq
);
	uisfc_pkg::uisfc_src_t cur;
	uisfc_pkg::uisfc_src_t next_cur;
	logic rd_ok;
	logic wr_ok;
	logic rd_isr;
	logic rd_lsr;
	logic rd_msr;
	logic rd_rhr;
	logic wr_fcr;
	logic wr_thr;
	logic [LEVEL_W-1:0] tx_trig;
	logic [LEVEL_W-1:0] rx_trig;
	logic tx_below;
	logic tx_empty;
	logic [uisfc_pkg::NE-1:0] ev_level;
	logic [uisfc_pkg::NE-1:0] rise;
	logic [uisfc_pkg::NF-1:0] flag_set;
	logic [uisfc_pkg::NF-1:0] flag_clr;
	logic [uisfc_pkg::NF-1:0] pend;
	logic rx_pend;
	logic to_expire;
	logic [uisfc_pkg::CNT_W-1:0] to_limit;
	logic cur_live;
	logic [5:0] code;
	logic [7:0] isr_now;

	// Divisor latch access shadows the data and INTERRUPT_SOURCE_REG/FIFO_CONTROL_REG addresses
	assign rd_ok = bus.rd & ~divisor_sel;
	assign wr_ok = bus.wr & ~divisor_sel;
	assign rd_isr = rd_ok && bus.addr == uisfc_pkg::ADDR_ISR;
	assign rd_rhr = rd_ok && bus.addr == uisfc_pkg::ADDR_DATA;
	assign rd_lsr = bus.rd && bus.addr == uisfc_pkg::ADDR_LSR;
	assign rd_msr = bus.rd && bus.addr == uisfc_pkg::ADDR_MSR;
	assign wr_fcr = wr_ok && bus.addr == uisfc_pkg::ADDR_ISR;
	assign wr_thr = wr_ok && bus.addr == uisfc_pkg::ADDR_DATA;

	assign tx_trig = uisfc_pkg::TX_TRIG[fifo_control_reg.tx_sel];
	assign rx_trig = uisfc_pkg::RX_TRIG[fifo_control_reg.rx_sel];

	// Without FIFOs only the empty holding register counts
	assign tx_below = fifo_control_reg.fifo_en && tx_level < tx_trig;
	assign tx_empty = tx_level == '0;

	assign ev_level[uisfc_pkg::EV_EMPTY] = tx_empty;
	assign ev_level[uisfc_pkg::EV_BELOW] = tx_below;
	assign ev_level[uisfc_pkg::EV_MODEM] =
		|modem_status[uisfc_pkg::MSR_DLT_HI:uisfc_pkg::MSR_DLT_LO];
	assign ev_level[uisfc_pkg::EV_LINE] =
		|line_status[uisfc_pkg::LSR_ERR_HI:uisfc_pkg::LSR_ERR_LO];
	assign ev_level[uisfc_pkg::EV_RTS] = rts_n;
	assign ev_level[uisfc_pkg::EV_CTS] = cts_n;

	uisfc_edge #(
		.W(uisfc_pkg::NE)
	) u_edge (
		.clk(clk),
		.reset(reset),
		.level(ev_level),
		.rise(rise)
	);

	assign to_limit = (uisfc_pkg::CNT_W)'(uisfc_pkg::TO_CHARS * char_bits)
		+ uisfc_pkg::TO_EXTRA_BITS;

	uisfc_timeout #(
		.CNT_W(uisfc_pkg::CNT_W)
	) u_timeout (
		.clk(clk),
		.reset(reset),
		.bit_tick(bit_tick),
		.restart(rx_push | rd_rhr),
		.run(fifo_control_reg.fifo_en && rx_level != '0),
		.limit(to_limit),
		.expire(to_expire)
	);

	assign flag_set[uisfc_pkg::F_LINE] =
		int_enable[uisfc_pkg::IER_LINE] & rise[uisfc_pkg::EV_LINE];
	assign flag_set[uisfc_pkg::F_MODEM] =
		int_enable[uisfc_pkg::IER_MODEM] & rise[uisfc_pkg::EV_MODEM];
	assign flag_set[uisfc_pkg::F_TO] = int_enable[uisfc_pkg::IER_RX] & to_expire;
	assign flag_set[uisfc_pkg::F_TX] = int_enable[uisfc_pkg::IER_TX]
		& (rise[uisfc_pkg::EV_BELOW] | rise[uisfc_pkg::EV_EMPTY]);
	assign flag_set[uisfc_pkg::F_XOFF] =
		enhanced_en & int_enable[uisfc_pkg::IER_XOFF] & xoff_match;
	assign flag_set[uisfc_pkg::F_SPEC] =
		enhanced_en & int_enable[uisfc_pkg::IER_XOFF] & special_match;
	assign flag_set[uisfc_pkg::F_FLOW] = enhanced_en & ((rise[uisfc_pkg::EV_CTS]
		& auto_cts_en & int_enable[uisfc_pkg::IER_CTS]) | (rise[uisfc_pkg::EV_RTS]
		& auto_rts_en & int_enable[uisfc_pkg::IER_RTS]));

	// INTERRUPT_SOURCE_REG reads only clear the source that the read actually reported
	assign flag_clr[uisfc_pkg::F_LINE] = rd_lsr;
	assign flag_clr[uisfc_pkg::F_MODEM] = rd_msr;
	assign flag_clr[uisfc_pkg::F_FLOW] = rd_msr;
	assign flag_clr[uisfc_pkg::F_TO] = rd_rhr;
	assign flag_clr[uisfc_pkg::F_TX] =
		wr_thr | (rd_isr && cur == uisfc_pkg::SRC_TRANSMIT_READY);
	assign flag_clr[uisfc_pkg::F_XOFF] =
		xon_match | (rd_isr && cur == uisfc_pkg::SRC_XOFF);
	assign flag_clr[uisfc_pkg::F_SPEC] =
		rx_push | (rd_isr && cur == uisfc_pkg::SRC_XOFF);

	// Set wins over clear so a same-cycle event is kept
	generate
		for (genvar i = 0; i < uisfc_pkg::NF; i++) begin : g_flag
			always_ff @(posedge clk) begin
				if (reset) begin
					pend[i] <= 1'b0;
				end else if (flag_set[i]) begin
					pend[i] <= 1'b1;
				end else if (flag_clr[i]) begin
					pend[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Level driven: drops when reads take the FIFO under trigger, or empty it with FIFOs off
	assign rx_pend = int_enable[uisfc_pkg::IER_RX]
		& (fifo_control_reg.fifo_en ? rx_level >= rx_trig : rx_level != '0);

	always_comb begin
		unique case (cur)
			uisfc_pkg::SRC_NONE: cur_live = 1'b0;
			uisfc_pkg::SRC_LINE: cur_live = pend[uisfc_pkg::F_LINE];
			uisfc_pkg::SRC_TIMEOUT: cur_live = pend[uisfc_pkg::F_TO];
			uisfc_pkg::SRC_RECEIVE_READY: cur_live = rx_pend;
			uisfc_pkg::SRC_TRANSMIT_READY: cur_live = pend[uisfc_pkg::F_TX];
			uisfc_pkg::SRC_MODEM: cur_live = pend[uisfc_pkg::F_MODEM];
			uisfc_pkg::SRC_XOFF: cur_live = pend[uisfc_pkg::F_XOFF] | pend[uisfc_pkg::F_SPEC];
			uisfc_pkg::SRC_FLOW: cur_live = pend[uisfc_pkg::F_FLOW];
			default: cur_live = 1'b0;
		endcase
	end

	// A live source is never pre-empted, which keeps the INTERRUPT_SOURCE_REG pointer stable
	always_comb begin
		next_cur = cur;
		if (!cur_live) begin
			if (pend[uisfc_pkg::F_LINE]) begin
				next_cur = uisfc_pkg::SRC_LINE;
			end else if (pend[uisfc_pkg::F_TO]) begin
				next_cur = uisfc_pkg::SRC_TIMEOUT;
			end else if (rx_pend) begin
				next_cur = uisfc_pkg::SRC_RECEIVE_READY;
			end else if (pend[uisfc_pkg::F_TX]) begin
				next_cur = uisfc_pkg::SRC_TRANSMIT_READY;
			end else if (pend[uisfc_pkg::F_MODEM]) begin
				next_cur = uisfc_pkg::SRC_MODEM;
			end else if (pend[uisfc_pkg::F_XOFF] | pend[uisfc_pkg::F_SPEC]) begin
				next_cur = uisfc_pkg::SRC_XOFF;
			end else if (pend[uisfc_pkg::F_FLOW]) begin
				next_cur = uisfc_pkg::SRC_FLOW;
			end else begin
				next_cur = uisfc_pkg::SRC_NONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cur <= uisfc_pkg::SRC_NONE;
			irq <= 1'b0;
		end else begin
			cur <= next_cur;
			irq <= next_cur != uisfc_pkg::SRC_NONE;
		end
	end

	always_comb begin
		unique case (cur)
			uisfc_pkg::SRC_NONE: code = uisfc_pkg::CODE_NONE;
			uisfc_pkg::SRC_LINE: code = uisfc_pkg::CODE_LINE;
			uisfc_pkg::SRC_TIMEOUT: code = uisfc_pkg::CODE_TIMEOUT;
			uisfc_pkg::SRC_RECEIVE_READY: code = uisfc_pkg::CODE_RECEIVE_READY;
			uisfc_pkg::SRC_TRANSMIT_READY: code = uisfc_pkg::CODE_TRANSMIT_READY;
			uisfc_pkg::SRC_MODEM: code = uisfc_pkg::CODE_MODEM;
			uisfc_pkg::SRC_XOFF: code = uisfc_pkg::CODE_XOFF;
			uisfc_pkg::SRC_FLOW: code = uisfc_pkg::CODE_FLOW;
			default: code = uisfc_pkg::CODE_NONE;
		endcase
	end

	assign isr_now = {{2{fifo_control_reg.fifo_en}},
		code & ~(enhanced_en ? 6'h00 : uisfc_pkg::CODE_EFR_MASK)};

	// Snapshot taken on the read so the host sees what it serviced
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= uisfc_pkg::ISR_RESET;
		end else if (rd_isr) begin
			rd_data <= isr_now;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fifo_control_reg <= uisfc_pkg::FCR_RESET;
		end else if (wr_fcr) begin
			if (bus.wdata[uisfc_pkg::FCR_EN]) begin
				fifo_control_reg.fifo_en <= 1'b1;
				fifo_control_reg.dma_mode <= bus.wdata[uisfc_pkg::FCR_DMA];
				fifo_control_reg.rx_sel <= bus.wdata[uisfc_pkg::FCR_RXT_LO +: 2];
				if (enhanced_en) begin
					fifo_control_reg.tx_sel <= bus.wdata[uisfc_pkg::FCR_TXT_LO +: 2];
				end
			end else begin
				fifo_control_reg.fifo_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_fifo_reset <= 1'b0;
			tx_fifo_reset <= 1'b0;
		end else begin
			rx_fifo_reset <= wr_fcr & bus.wdata[uisfc_pkg::FCR_EN]
				& bus.wdata[uisfc_pkg::FCR_RXRST];
			tx_fifo_reset <= wr_fcr & bus.wdata[uisfc_pkg::FCR_EN]
				& bus.wdata[uisfc_pkg::FCR_TXRST];
		end
	end

	property p_line_first;
		@(posedge clk) disable iff (reset)
		(!cur_live && pend[uisfc_pkg::F_LINE])
			|=> cur == uisfc_pkg::SRC_LINE;
	endproperty
	a_line_first: assert property (p_line_first) else $error("line not first");

	property p_hold;
		@(posedge clk) disable iff (reset)
		(cur == uisfc_pkg::SRC_TRANSMIT_READY && pend[uisfc_pkg::F_TX] && !flag_clr[uisfc_pkg::F_TX])
			|=> cur == uisfc_pkg::SRC_TRANSMIT_READY;
	endproperty
	a_hold: assert property (p_hold) else $error("served source pre-empted");

	property p_idle_code;
		@(posedge clk) disable iff (reset)
		rd_isr && cur == uisfc_pkg::SRC_NONE |=> rd_data[5:0] == uisfc_pkg::CODE_NONE;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle code wrong");

	property p_lsr_clear;
		@(posedge clk) disable iff (reset)
		rd_lsr && !flag_set[uisfc_pkg::F_LINE] |=> !pend[uisfc_pkg::F_LINE];
	endproperty
	a_lsr_clear: assert property (p_lsr_clear) else $error("line not cleared");

	property p_msr_clear;
		@(posedge clk) disable iff (reset)
		rd_msr && !flag_set[uisfc_pkg::F_MODEM] && !flag_set[uisfc_pkg::F_FLOW]
			|=> !pend[uisfc_pkg::F_MODEM] && !pend[uisfc_pkg::F_FLOW];
	endproperty
	a_msr_clear: assert property (p_msr_clear) else $error("modem not cleared");

	property p_thr_clear;
		@(posedge clk) disable iff (reset)
		wr_thr && !flag_set[uisfc_pkg::F_TX] |=> !pend[uisfc_pkg::F_TX];
	endproperty
	a_thr_clear: assert property (p_thr_clear) else $error("tx not cleared");

	property p_set_wins;
		@(posedge clk) disable iff (reset)
		flag_set[uisfc_pkg::F_TO] && rd_rhr |=> pend[uisfc_pkg::F_TO];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("timeout event lost");

	property p_fifo_bits;
		@(posedge clk) disable iff (reset)
		rd_isr |=> rd_data[7:6] == {2{$past(fifo_control_reg.fifo_en)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) else $error("fifo status bits wrong");

	property p_fcr_ignore;
		@(posedge clk) disable iff (reset)
		wr_fcr && !bus.wdata[uisfc_pkg::FCR_EN]
			|=> !fifo_control_reg.fifo_en && $stable(fifo_control_reg.dma_mode) && !rx_fifo_reset;
	endproperty
	a_fcr_ignore: assert property (p_fcr_ignore) else $error("fcr bits taken");

	property p_rx_reset_pulse;
		@(posedge clk) disable iff (reset)
		wr_fcr && bus.wdata[uisfc_pkg::FCR_EN] && bus.wdata[uisfc_pkg::FCR_RXRST]
			##1 !(wr_fcr && bus.wdata[uisfc_pkg::FCR_RXRST])
			|-> rx_fifo_reset ##1 !rx_fifo_reset;
	endproperty
	a_rx_reset_pulse: assert property (p_rx_reset_pulse) else $error("rx reset pulse");

	property p_rx_level;
		@(posedge clk) disable iff (reset)
		fifo_control_reg.fifo_en && int_enable[uisfc_pkg::IER_RX] && rx_level >= rx_trig
			&& !pend[uisfc_pkg::F_LINE] && !pend[uisfc_pkg::F_TO] |=> ##[0:1] irq;
	endproperty
	a_rx_level: assert property (p_rx_level) else $error("rx ready missing");
endmodule

// ### tb/uisfc_host.sv
// Purpose: Host processor model on the register bus
// Assumes: Bus changes only at falling clock edges
// Notes: gap sets idle cycles after an access, so the host can be prompt or slow
`timescale 1ns/1ps
module uisfc_host (
	input wire logic clk,
	output uisfc_pkg::uisfc_bus_t bus
);
	initial begin
		bus = '0;
	end
	// Released address and data are inverted so stale values never look valid
	task automatic access(input logic [2:0] a, input logic w, input logic [7:0] d, input int gap);
		@(negedge clk);
		bus = '{addr: a, rd: !w, wr: w, wdata: d};
		@(negedge clk);
		bus = '{addr: ~a, rd: 1'h0, wr: 1'h0, wdata: ~d};
		repeat (gap) @(negedge clk);
	endtask
	task automatic rd(input logic [2:0] a, input int gap);
		access(a, 1'h0, 8'h00, gap);
	endtask
	task automatic wr_fcr(input logic [7:0] d, input int gap);
		access(uisfc_pkg::ADDR_ISR, 1'h1, d | 8'h01, gap);
	endtask
endmodule

// ### tb/uisfc_core_tb.sv
// Purpose: Self-checking bench for the interrupt status and FIFO control block
// Assumes: Host model drives the bus; the bench drives receiver and line inputs
// Notes: Status bytes are noted in a queue and compared by a monitor process
`timescale 1ns/1ps
module uisfc_core_tb;
	logic clk = 1'h0;
	logic reset = 1'h1;
	uisfc_pkg::uisfc_bus_t bus;
	uisfc_pkg::uisfc_fcr_t fifo_control_reg;
	logic enhanced_en = 1'h0, auto_cts_en = 1'h0, auto_rts_en = 1'h0, cts_n = 1'h0, rts_n = 1'h0;
	logic [4:0] pl = 5'h00;
	logic [7:0] int_enable = 8'hFF, line_status = 8'h00, modem_status = 8'h00, rd_data;
	logic [3:0] char_bits = 4'hA;
	logic [5:0] rx_level = 6'h00, tx_level = 6'h20;
	logic [5:0] rxt [4] = '{6'h08, 6'h10, 6'h18, 6'h1E};
	logic rx_fifo_reset, tx_fifo_reset, irq, fifo_on = 1'h0, rd_seen = 1'h0, rd_seen2 = 1'h0;
	logic [7:0] exp_q [$];
	logic [31:0] v;
	int mismatches = 0, cmp_count = 0, rxp = 0, txp = 0, seed = 53, a, b;

	initial begin
		forever #2 clk = ~clk;
	end

	uisfc_host host_u (.clk(clk), .bus(bus));
	uisfc_core dut_u (.clk(clk), .reset(reset), .bus(bus), .divisor_sel(1'h0),
		.enhanced_en(enhanced_en), .auto_cts_en(auto_cts_en), .auto_rts_en(auto_rts_en),
		.int_enable(int_enable), .line_status(line_status), .modem_status(modem_status),
		.cts_n(cts_n), .rts_n(rts_n), .xoff_match(pl[0]), .xon_match(pl[1]),
		.special_match(pl[2]), .rx_push(pl[3]), .bit_tick(pl[4]), .char_bits(char_bits),
		.rx_level(rx_level), .tx_level(tx_level), .rd_data(rd_data), .fifo_control_reg(fifo_control_reg),
		.rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .irq(irq));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Status answer is compared two edges after the strobe, well inside its hold
	always @(posedge clk) begin
		rd_seen <= bus.rd && bus.addr == uisfc_pkg::ADDR_ISR;
		rd_seen2 <= rd_seen;
	end
	always @(negedge clk) begin
		rxp <= rxp + int'(rx_fifo_reset);
		txp <= txp + int'(tx_fifo_reset);
		if (rd_seen2) begin
			chk(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
		end
	end

	task automatic expect_src(input logic [5:0] code);
		repeat (3) @(negedge clk);
		chk({7'h00, irq}, {7'h00, code != uisfc_pkg::CODE_NONE});
		exp_q.push_back({fifo_on, fifo_on, code});
		host_u.rd(uisfc_pkg::ADDR_ISR, 2);
	endtask

	task automatic pulse(input int i);
		@(negedge clk);
		pl[i] = 1'h1;
		@(negedge clk);
		pl[i] = 1'h0;
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// The sequence needs about six hundred cycles; the 12500-cycle limit leaves ample margin
	initial begin
		#50000;
		mismatches++;
		end_sim();
	end

	initial begin
		repeat (10) @(negedge clk);
		reset = 1'h0;
		expect_src(uisfc_pkg::CODE_NONE);
		host_u.wr_fcr(8'h01, 1);
		fifo_on = 1'h1;
		chk({2'h0, fifo_control_reg}, 8'h20);
		expect_src(uisfc_pkg::CODE_NONE);
		a = rxp;
		b = txp;
		host_u.wr_fcr(8'h03, 0);
		host_u.wr_fcr(8'h05, 2);
		chk(8'(rxp - a), 8'h01);
		chk(8'(txp - b), 8'h01);
		host_u.wr_fcr(8'h09, 1);
		chk({2'h0, fifo_control_reg}, 8'h30);
		a = rxp;
		v = $random(seed);
		host_u.access(uisfc_pkg::ADDR_ISR, 1'h1, v[7:0] & 8'hFE, 2);
		fifo_on = 1'h0;
		chk({2'h0, fifo_control_reg}, 8'h10);
		chk(8'(rxp - a), 8'h00);
		expect_src(uisfc_pkg::CODE_NONE);
		host_u.wr_fcr(8'h10, 1);
		fifo_on = 1'h1;
		chk({2'h0, fifo_control_reg}, 8'h20);
		enhanced_en = 1'h1;
		host_u.wr_fcr(8'h10, 1);
		chk({2'h0, fifo_control_reg}, 8'h24);
		tx_level = 6'h09;
		expect_src(uisfc_pkg::CODE_NONE);
		tx_level = 6'h07;
		expect_src(uisfc_pkg::CODE_TRANSMIT_READY);
		expect_src(uisfc_pkg::CODE_NONE);
		tx_level = 6'h20;
		host_u.wr_fcr(8'h00, 1);
		tx_level = 6'h0F;
		expect_src(uisfc_pkg::CODE_TRANSMIT_READY);
		expect_src(uisfc_pkg::CODE_NONE);
		tx_level = 6'h00;
		expect_src(uisfc_pkg::CODE_TRANSMIT_READY);
		// Refill and empty again so the TRANSMIT_HOLDING_REG write, not an INTERRUPT_SOURCE_REG read, does the clearing
		tx_level = 6'h20;
		@(negedge clk);
		tx_level = 6'h00;
		repeat (3) @(negedge clk);
		chk({7'h00, irq}, 8'h01);
		host_u.access(uisfc_pkg::ADDR_DATA, 1'h1, 8'h5A, 1);
		expect_src(uisfc_pkg::CODE_NONE);
		tx_level = 6'h20;
		for (int i = 0; i < 4; i++) begin
			host_u.wr_fcr({i[1:0], 6'h00}, 1);
			chk({2'h0, fifo_control_reg}, 8'h20 | 8'(i));
			rx_level = rxt[i] - 6'h01;
			expect_src(uisfc_pkg::CODE_NONE);
			rx_level = rxt[i];
			expect_src(uisfc_pkg::CODE_RECEIVE_READY);
			expect_src(uisfc_pkg::CODE_RECEIVE_READY);
			rx_level = rxt[i] - 6'h01;
			expect_src(uisfc_pkg::CODE_NONE);
		end
		rx_level = 6'h01;
		host_u.wr_fcr(8'h00, 1);
		pulse(3);
		// One bit time short of four characters plus twelve bits
		for (int i = 0; i < 4 * int'(char_bits) + 11; i++) pulse(4);
		expect_src(uisfc_pkg::CODE_NONE);
		// Last tick comes one cycle before a RECEIVE_HOLDING_REG read, so expiry and clear fall in one cycle
		fork
			pulse(4);
			begin
				@(negedge clk);
				host_u.rd(uisfc_pkg::ADDR_DATA, 1);
			end
		join
		expect_src(uisfc_pkg::CODE_TIMEOUT);
		host_u.rd(uisfc_pkg::ADDR_DATA, 1);
		expect_src(uisfc_pkg::CODE_NONE);
		rx_level = 6'h00;
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			modem_status = (8'h01 << k) | (v[15:8] & 8'hF0);
			expect_src(uisfc_pkg::CODE_MODEM);
			line_status = (8'h02 << k) | (v[7:0] & 8'hE1);
			expect_src(uisfc_pkg::CODE_MODEM);
			host_u.rd(uisfc_pkg::ADDR_MSR, 1);
			expect_src(uisfc_pkg::CODE_LINE);
			host_u.rd(uisfc_pkg::ADDR_LSR, 1);
			expect_src(uisfc_pkg::CODE_NONE);
			modem_status = 8'h00;
			line_status = 8'h00;
			// Let the idle level be sampled so the next pass makes a fresh rise
			@(negedge clk);
		end
		pulse(0);
		expect_src(uisfc_pkg::CODE_XOFF);
		expect_src(uisfc_pkg::CODE_NONE);
		pulse(0);
		pulse(1);
		expect_src(uisfc_pkg::CODE_NONE);
		pulse(2);
		repeat (3) @(negedge clk);
		chk({7'h00, irq}, 8'h01);
		pulse(3);
		expect_src(uisfc_pkg::CODE_NONE);
		auto_cts_en = 1'h1;
		auto_rts_en = 1'h1;
		cts_n = 1'h1;
		expect_src(uisfc_pkg::CODE_FLOW);
		host_u.rd(uisfc_pkg::ADDR_MSR, 1);
		rts_n = 1'h1;
		expect_src(uisfc_pkg::CODE_FLOW);
		host_u.rd(uisfc_pkg::ADDR_MSR, 1);
		expect_src(uisfc_pkg::CODE_NONE);
		enhanced_en = 1'h0;
		pulse(0);
		expect_src(uisfc_pkg::CODE_NONE);
		end_sim();
	end
endmodule
